// ==== core/flow_ctl_pkg.sv ====
// constants and types for the program-flow execute control block
package flow_ctl_pkg;
  // ----------------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_SAVE   = 8'h08;
  localparam logic [7:0] OFS_PC     = 8'h0c;
  localparam int CTRL_EXPAND   = 0;
  localparam int CTRL_IEN_SET  = 1;
  localparam int CTRL_IEN_CLR  = 2;
  localparam int ST_IEN        = 0;
  localparam int ST_TAKEN      = 1;
  localparam int ST_RETPEND    = 2;
  localparam int ST_BANK       = 3;
  // ----------------------------------------------------------------
  // instruction word fields
  // ----------------------------------------------------------------
  localparam int W_SEL_LO      = 1;
  localparam int W_OVF_SEL     = 3;
  localparam int W_INV_SEL     = 7;
  localparam int W_SKIP_MARK   = 8;
  localparam int W_GRP_LO      = 9;
  localparam int W_GRP_HI      = 12;
  localparam int W_F09         = 9;
  localparam int W_F10         = 10;
  localparam int W_IND         = 1;
  localparam int W_IEN_BIT     = 3;
  localparam int W_IDIS_BIT    = 4;
  localparam int W_IRET_BIT    = 2;
  localparam int A_SIGN        = 12;
  localparam int A_BIT1        = 1;
  localparam int A_BIT3        = 3;
  localparam logic [13:1] INT_VECTOR = 13'h0002;
  localparam logic [13:1] PC_ZERO    = 13'h0000;
  typedef enum logic [2:0] {OP_NONE, OP_JUMP, OP_JUMP_STORE,
                            OP_IRQ_ON, OP_IRQ_OFF, OP_IRQ_RET} flow_op_t;
  typedef enum {PH_IDLE, PH_F4, PH_F5, PH_E1, PH_E2, PH_E3, PH_E4, PH_E5, PH_E6} phase_t;
endpackage

// ==== core/flow_ctl.sv ====
// program-flow execute control: skip group, jump, jump-and-store, interrupt enable
//
// Behaviour
// RL1: skip decode: bits 9-12 zero, bit 8 one
// RL2: skip pulses pc advance at execute phase 1
// RL3: bit7 set: skip when accumulator sign zero
// RL4: overflow select: skip only when overflow set
// RL5: unconditional skip always advances pc
// RL6: conditions ORed, ANDed when invert bit set
// RL7: jump group decoded from fetched bits 9,10
// RL8: jump clears pc phase 2, loads phase 3
// RL9: jump execute cycle ends after phase 3
// RL10: indirect jump swaps bank bit and pc bit13
// RL11: after return transfer, restore from save register
// RL12: restore strobe clears return pending flag
// RL13: jump-and-store writes the current pc to memory at phase 1, before the phase 4 increment
// RL14: phase 1 resets address/data logic, starts memory
// RL15: memory cycle clear/write, pc into data register
// RL16: jump-and-store increments pc in phase 4
// RL17: jump-and-store runs phases 5, 6 then ends
// RL18: indirect jump-and-store swaps/restores like jump
// RL19: peripherals pull shared active-low request line
// RL20: enable instruction sets enable flag phase 1
// RL21: inhibit instruction clears enable flag phase 1
// RL22: master clear clears enable flag synchronously, at the next clock edge
// RL23: taken flag set clears enable flag
// RL24: taken flag set at fetch 4 when enabled
// RL25: taken interrupt forces fetch address 00002
// RL26: return transfer saves A1,A3, sets pending
`timescale 1ns/100ps
module flow_ctl
  import flow_ctl_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // processor timing and instruction
  input  wire logic        fetch_phase_4,
  input  wire logic        fetch_phase_5,
  input  wire logic        exec_start,
  input  wire logic        first_indirect_fetch,
  input  wire logic [12:1] instr_word,
  input  wire logic [12:1] accumulator,
  input  wire logic        adder_overflow_flag,
  input  wire logic [12:1] eff_addr,
  input  wire logic        master_clear_pulse,
  input  wire logic        shared_irq_line_n,
  // outputs toward the datapath
  output logic             skip_group_decode,
  output logic             jump_group_decode,
  output logic             pc_advance_pulse,
  output logic             execute_phase_1,
  output logic             exec_done,
  output logic [13:1]      pc_q,
  output logic             mem_addr_reset,
  output logic             mem_start,
  output logic             mem_clear_write,
  output logic [13:1]      mem_data_q,
  output logic             fetch_addr_force,
  output logic [13:1]      fetch_addr,
  output logic             interrupt_taken_flag,
  output logic             interrupt_enable_q,
  output logic             bank_bit,
  output logic             pc_bit_thirteen
);
  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  phase_t   ph_q;
  flow_op_t op_q;
  logic     expand_q;
  logic     eff_addr_bit_thirteen;
  logic     return_pending_flag;
  logic     save_bank_q;
  logic     save_p13_q;
  logic     skip_cond;
  logic     any_sel;
  logic     all_true;
  logic     ind_q;
  logic     restore_strobe;
  logic     jump_op;
  logic     jump_and_store_op;
  logic     interrupt_enable_op;
  logic     interrupt_inhibit_op;
  logic     interrupt_return_transfer_op;
  logic     skip_if_positive;
  logic     skip_if_overflow;
  logic     skip_unconditional;
  logic     irq_req;
  logic     apb_wr;

  assign skip_group_decode = (instr_word[W_GRP_HI:W_GRP_LO] == 4'h0)
                           && instr_word[W_SKIP_MARK]; // see RL1
  assign jump_group_decode = instr_word[W_F10] & ~instr_word[W_F09]; // see RL7
  assign jump_op           = jump_group_decode & ~instr_word[W_SKIP_MARK];
  assign jump_and_store_op = jump_group_decode & instr_word[W_SKIP_MARK];
  assign interrupt_enable_op  = (instr_word[W_GRP_HI:W_GRP_LO] == 4'h0) & ~instr_word[W_SKIP_MARK]
                              & instr_word[W_IEN_BIT];
  assign interrupt_inhibit_op = (instr_word[W_GRP_HI:W_GRP_LO] == 4'h0) & ~instr_word[W_SKIP_MARK]
                              & instr_word[W_IDIS_BIT] & ~instr_word[W_IEN_BIT];
  assign interrupt_return_transfer_op = (instr_word[W_GRP_HI:W_GRP_LO] == 4'h0)
                              & ~instr_word[W_SKIP_MARK] & instr_word[W_IRET_BIT]
                              & ~instr_word[W_IEN_BIT] & ~instr_word[W_IDIS_BIT];
  assign irq_req = ~shared_irq_line_n; // see RL19

  // ------------------------------------------------------------------
  // skip logic
  // ------------------------------------------------------------------
  // sign test is active when bit 7 is set; overflow test on bit 3
  assign skip_if_positive   = instr_word[W_INV_SEL];
  assign skip_if_overflow   = instr_word[W_OVF_SEL] & ~instr_word[W_INV_SEL];
  assign skip_unconditional = ~instr_word[W_INV_SEL] & ~instr_word[W_OVF_SEL];
  assign any_sel  = instr_word[W_OVF_SEL] & adder_overflow_flag;
  assign all_true = ~accumulator[A_SIGN]
                  & (~instr_word[W_OVF_SEL] | adder_overflow_flag);
  always_comb
  begin
    if (skip_if_positive)
      skip_cond = all_true; // see RL3, RL6
    else if (skip_if_overflow)
      skip_cond = any_sel; // see RL4, RL6
    else
      skip_cond = skip_unconditional; // see RL5
  end

  // ------------------------------------------------------------------
  // execute phase sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph_q <= PH_IDLE;
      op_q <= OP_NONE;
      ind_q <= 1'b0;
    end
    else
    begin
      unique case (ph_q)
        PH_IDLE:
        begin
          if (exec_start)
          begin
            ph_q  <= PH_E1;
            ind_q <= instr_word[W_IND];
            if (jump_and_store_op)
              op_q <= OP_JUMP_STORE;
            else if (jump_op)
              op_q <= OP_JUMP;
            else
              op_q <= OP_NONE;
          end
        end
        PH_E1:   ph_q <= (op_q == OP_NONE) ? PH_IDLE : PH_E2;
        PH_E2:   ph_q <= PH_E3;
        PH_E3:   ph_q <= (op_q == OP_JUMP_STORE) ? PH_E4 : PH_IDLE; // see RL9
        PH_E4:   ph_q <= PH_E5;
        PH_E5:   ph_q <= PH_E6; // see RL17
        PH_E6:   ph_q <= PH_IDLE;
        PH_F4:   ph_q <= PH_IDLE;
        PH_F5:   ph_q <= PH_IDLE;
      endcase
    end
  end
  assign execute_phase_1 = (ph_q == PH_E1);
  assign exec_done = ((ph_q == PH_E1) && (op_q == OP_NONE))
                   || ((ph_q == PH_E3) && (op_q == OP_JUMP)) || (ph_q == PH_E6);

  // pc advance: skip at phase 1, jump-and-store at phase 4
  assign pc_advance_pulse = (execute_phase_1 && skip_group_decode && skip_cond) // see RL2
                          || ((ph_q == PH_E4) && (op_q == OP_JUMP_STORE)); // see RL16

  // ------------------------------------------------------------------
  // program counter
  // ------------------------------------------------------------------
  assign restore_strobe = (ph_q == PH_E3) && (op_q != OP_NONE) && ind_q && expand_q
                        && return_pending_flag; // see RL11, RL18
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pc_q <= PC_ZERO;
    else if (apb_wr && (paddr == OFS_PC))
      pc_q <= pwdata[12:0];
    else if (ph_q == PH_E2 && op_q != OP_NONE)
      pc_q <= PC_ZERO; // see RL8
    else if (ph_q == PH_E3 && op_q != OP_NONE)
    begin
      pc_q[12:1] <= eff_addr; // see RL8
      if (restore_strobe)
        pc_q[13] <= save_p13_q; // see RL11
      else if (ind_q && expand_q)
        pc_q[13] <= eff_addr_bit_thirteen; // see RL10, RL18
    end
    else if (execute_phase_1 && op_q != OP_NONE && ind_q && expand_q && return_pending_flag)
      pc_q[13] <= 1'b0; // see RL11
    else if (pc_advance_pulse)
      pc_q <= pc_q + 13'h0001;
  end
  assign pc_bit_thirteen = pc_q[13];

  // ------------------------------------------------------------------
  // bank bit and effective address bit 13
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      eff_addr_bit_thirteen <= 1'b0;
    else if (fetch_phase_5)
      eff_addr_bit_thirteen <= bank_bit; // see RL10
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bank_bit <= 1'b0;
    else if (execute_phase_1 && op_q != OP_NONE && ind_q && expand_q)
      bank_bit <= return_pending_flag ? 1'b0 : pc_q[13]; // see RL10, RL11
    else if (restore_strobe)
      bank_bit <= save_bank_q; // see RL11
  end

  // ------------------------------------------------------------------
  // return transfer: save register and pending flag
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      save_bank_q <= 1'b0;
      save_p13_q  <= 1'b0;
    end
    else if (ph_q == PH_IDLE && exec_start && interrupt_return_transfer_op)
    begin
      save_bank_q <= accumulator[A_BIT1]; // see RL26
      save_p13_q  <= accumulator[A_BIT3];
    end
  end
  // a new return transfer in the strobe cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      return_pending_flag <= 1'b0;
    else if (ph_q == PH_IDLE && exec_start && interrupt_return_transfer_op)
      return_pending_flag <= 1'b1; // see RL26
    else if (restore_strobe)
      return_pending_flag <= 1'b0; // see RL12
  end

  // ------------------------------------------------------------------
  // jump-and-store memory write
  // ------------------------------------------------------------------
  assign mem_addr_reset  = execute_phase_1 && (op_q == OP_JUMP_STORE); // see RL14
  assign mem_start       = mem_addr_reset; // see RL14
  assign mem_clear_write = (op_q == OP_JUMP_STORE) && (ph_q != PH_IDLE); // see RL15
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mem_data_q <= PC_ZERO;
    else if (mem_addr_reset)
      mem_data_q <= pc_q; // see RL13, RL15
  end

  // ------------------------------------------------------------------
  // interrupt enable and taken flags
  // ------------------------------------------------------------------
  // taken flag: set at fetch 4 when enabled, reset at next fetch 4 once enable is gone
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      interrupt_taken_flag <= 1'b0;
    else if (master_clear_pulse)
      interrupt_taken_flag <= 1'b0;
    else if (fetch_phase_4 && interrupt_enable_q && irq_req && !first_indirect_fetch)
      interrupt_taken_flag <= 1'b1; // see RL24
    else if (fetch_phase_4 && !interrupt_enable_q)
      interrupt_taken_flag <= 1'b0; // taken flag reset at fetch 4 while enable is clear
    else if (execute_phase_1 && op_q == OP_NONE && interrupt_inhibit_op)
      interrupt_taken_flag <= 1'b0;
  end
  // clears in the same edge as taken sets, blocking further interrupts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      interrupt_enable_q <= 1'b0;
    else if (master_clear_pulse)
      interrupt_enable_q <= 1'b0; // see RL22
    else if (fetch_phase_4 && interrupt_enable_q && irq_req && !first_indirect_fetch)
      interrupt_enable_q <= 1'b0; // see RL23
    else if (execute_phase_1 && interrupt_inhibit_op)
      interrupt_enable_q <= 1'b0; // see RL21
    else if (execute_phase_1 && interrupt_enable_op)
      interrupt_enable_q <= 1'b1; // see RL20
    else if (apb_wr && paddr == OFS_CTRL && pwdata[CTRL_IEN_CLR])
      interrupt_enable_q <= 1'b0;
    else if (apb_wr && paddr == OFS_CTRL && pwdata[CTRL_IEN_SET])
      interrupt_enable_q <= 1'b1;
  end
  assign fetch_addr_force = interrupt_taken_flag; // see RL25
  assign fetch_addr       = INT_VECTOR;

  // ------------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign apb_wr  = psel && penable && pwrite;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      expand_q <= 1'b0;
    else if (apb_wr && paddr == OFS_CTRL)
      expand_q <= pwdata[CTRL_EXPAND];
  end
  always_comb
  begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      OFS_CTRL:   prdata[CTRL_EXPAND] = expand_q;
      OFS_STATUS:
      begin
        prdata[ST_IEN]     = interrupt_enable_q;
        prdata[ST_TAKEN]   = interrupt_taken_flag;
        prdata[ST_RETPEND] = return_pending_flag;
        prdata[ST_BANK]    = bank_bit;
      end
      OFS_SAVE:   prdata[1:0] = {save_p13_q, save_bank_q};
      OFS_PC:     prdata[12:0] = pc_q;
      default:    prdata = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_jump_ends: assert property (@(posedge pclk) disable iff (!presetn) // see RL9
    (ph_q == PH_E3 && op_q == OP_JUMP) |=> ph_q == PH_IDLE)
    else $error("jump did not end after phase 3");
  a_store_len: assert property (@(posedge pclk) disable iff (!presetn) // see RL17
    (ph_q == PH_E1 && op_q == OP_JUMP_STORE) |-> ##5 ph_q == PH_E6)
    else $error("jump-and-store phase count wrong");
  a_pc_clear: assert property (@(posedge pclk) disable iff (!presetn) // see RL8
    (ph_q == PH_E2 && op_q == OP_JUMP && !(apb_wr && paddr == OFS_PC)) |=> pc_q[12:1] == 12'h000)
    else $error("pc not cleared in phase 2");
  a_pc_load: assert property (@(posedge pclk) disable iff (!presetn) // see RL8
    (ph_q == PH_E3 && op_q != OP_NONE && !(apb_wr && paddr == OFS_PC))
      |=> pc_q[12:1] == $past(eff_addr))
    else $error("pc not loaded from effective address");
  a_store_inc: assert property (@(posedge pclk) disable iff (!presetn) // see RL16
    (ph_q == PH_E4 && op_q == OP_JUMP_STORE && !(apb_wr && paddr == OFS_PC))
      |=> pc_q == $past(pc_q) + 13'h0001)
    else $error("pc not advanced in phase 4");
  a_ret_clear: assert property (@(posedge pclk) disable iff (!presetn) // see RL12
    (restore_strobe && !(exec_start && ph_q == PH_IDLE)) |=> !return_pending_flag)
    else $error("pending flag survived restore");
  a_enb_taken: assert property (@(posedge pclk) disable iff (!presetn) // see RL23
    $rose(interrupt_taken_flag) |-> !interrupt_enable_q)
    else $error("enable stayed set after interrupt taken");
  a_mclr_enb: assert property (@(posedge pclk) disable iff (!presetn) // see RL22
    master_clear_pulse |=> !interrupt_enable_q)
    else $error("master clear left interrupts enabled");
  a_skip_adv: assert property (@(posedge pclk) disable iff (!presetn) // see RL2, RL5
    (execute_phase_1 && skip_group_decode && !instr_word[W_INV_SEL] && !instr_word[W_OVF_SEL]
      && !(apb_wr && paddr == OFS_PC)) |=> pc_q == $past(pc_q) + 13'h0001)
    else $error("unconditional skip did not advance pc");
  a_store_data: assert property (@(posedge pclk) disable iff (!presetn) // see RL13
    mem_addr_reset |=> mem_data_q == $past(pc_q))
    else $error("stored pc value wrong");
  c_store_run: cover property (@(posedge pclk) disable iff (!presetn)
    ph_q == PH_E6);
  c_taken: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(interrupt_taken_flag));
  c_restore: cover property (@(posedge pclk) disable iff (!presetn)
    restore_strobe);
endmodule

// ==== tb/irq_peripherals.sv ====
// model of the peripherals sharing the active-low interrupt request line
`timescale 1ns/100ps
module irq_peripherals
#(
  parameter int N = 3
)
(
  // one request per peripheral
  input  wire logic [N-1:0] req,
  // shared request line
  output logic              shared_irq_line_n
);
  // ----------------------------------------------------------------
  // wired request line
  // ----------------------------------------------------------------
  // any requester pulls low; the pull-up wins when nobody asks
  assign shared_irq_line_n = ~(|req);
endmodule

// ==== tb/tb_flow_ctl.sv ====
// self-checking testbench for the program-flow execute control block
`timescale 1ns/100ps
module tb_flow_ctl;
  import flow_ctl_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        fetch_phase_4, fetch_phase_5, exec_start, first_indirect_fetch;
  logic [12:1] instr_word, accumulator, eff_addr;
  logic        adder_overflow_flag, master_clear_pulse, shared_irq_line_n;
  logic        skip_group_decode, jump_group_decode, pc_advance_pulse, execute_phase_1;
  logic        exec_done, mem_addr_reset, mem_start, mem_clear_write, fetch_addr_force;
  logic [13:1] pc_q, mem_data_q, fetch_addr, pc_e3;
  logic        interrupt_taken_flag, interrupt_enable_q, bank_bit, pc_bit_thirteen;
  logic        e1_seen, mem_e1, cw_seen;
  logic [2:0]  req;
  int          bad_count, n_checks, cycles, done_at, adv_at;

  flow_ctl u_flow_ctl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .fetch_phase_4, .fetch_phase_5, .exec_start,
    .first_indirect_fetch, .instr_word, .accumulator, .adder_overflow_flag, .eff_addr,
    .master_clear_pulse, .shared_irq_line_n, .skip_group_decode, .jump_group_decode,
    .pc_advance_pulse, .execute_phase_1, .exec_done, .pc_q, .mem_addr_reset, .mem_start,
    .mem_clear_write, .mem_data_q, .fetch_addr_force, .fetch_addr, .interrupt_taken_flag,
    .interrupt_enable_q, .bank_bit, .pc_bit_thirteen);

  irq_peripherals u_irq_peripherals (.req, .shared_irq_line_n);

  always #5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      bad_count++;
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // hang guard, well above the roughly 150 cycles the run needs
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      complete_run();
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // 4: fetch phase 4, 5: fetch phase 5, else master clear
  task automatic pulse(input int which);
    @(posedge pclk);
    if (which == 4) fetch_phase_4 <= 1'b1;
    else if (which == 5) fetch_phase_5 <= 1'b1;
    else master_clear_pulse <= 1'b1;
    @(posedge pclk);
    fetch_phase_4 <= 1'b0;
    fetch_phase_5 <= 1'b0;
    master_clear_pulse <= 1'b0;
    #1;
  endtask

  // runs one execute cycle and records when things happened
  task automatic exec_op(input logic [12:1] w);
    @(posedge pclk);
    instr_word <= w;
    exec_start <= 1'b1;
    @(posedge pclk);
    exec_start <= 1'b0;
    done_at = 0;
    adv_at = 0;
    for (int k = 1; k <= 8 && done_at == 0; k++)
    begin
      #1;
      if (k == 1)
      begin
        e1_seen = execute_phase_1;
        mem_e1 = mem_start & mem_addr_reset;
        cw_seen = mem_clear_write;
      end
      if (k == 3) pc_e3 = pc_q;
      if (pc_advance_pulse === 1'b1) adv_at = k;
      if (exec_done === 1'b1) done_at = k;
      @(posedge pclk);
    end
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_skip();
    logic [12:1] ws [7] = '{12'h0c0, 12'h0c0, 12'h084, 12'h084, 12'h080, 12'h0c4, 12'h0c4};
    logic [12:1] ac [7] = '{12'h000, 12'h800, 12'h800, 12'h000, 12'h800, 12'h000, 12'h000};
    logic        ov [7] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    int          ex [7] = '{1, 0, 1, 0, 1, 1, 0};
    for (int i = 0; i < 7; i++)
    begin
      @(posedge pclk);
      accumulator <= ac[i];
      adder_overflow_flag <= ov[i];
      exec_op(ws[i]);
      chk("skip decode", skip_group_decode, 1);
      chk("skip advance", adv_at, ex[i]);
      chk("skip e1", e1_seen, 1);
      chk("skip done", done_at, 1);
    end
  endtask

  task automatic t_jump();
    @(posedge pclk);
    eff_addr <= 12'h345;
    exec_op(12'h200);
    chk("jump decode", jump_group_decode, 1);
    chk("jump not skip", skip_group_decode, 0);
    chk("jump pc cleared", pc_e3, 0);
    chk("jump pc", pc_q, 13'h0345);
    chk("jump done", done_at, 3);
    @(posedge pclk);
    eff_addr <= 12'h123;
    exec_op(12'h280);
    chk("store mem start", mem_e1, 1);
    chk("store clear write", cw_seen, 1);
    chk("store data", mem_data_q, 13'h0345);
    chk("store pc cleared", pc_e3, 0);
    chk("store advance", adv_at, 4);
    chk("store pc", pc_q, 13'h0124);
    chk("store done", done_at, 6);
  endtask

  task automatic t_swap();
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_PC, 32'h1005);
    @(posedge pclk);
    eff_addr <= 12'h0a0;
    pulse(5);
    exec_op(12'h201);
    chk("swap pc", pc_q, 13'h00a0);
    chk("swap bank", bank_bit, 1);
    pulse(5);
    exec_op(12'h281);
    chk("store swap pc", pc_q, 13'h10a1);
    chk("store swap pc13", pc_bit_thirteen, 1);
    chk("store swap bank", bank_bit, 0);
  endtask

  task automatic t_return();
    @(posedge pclk);
    accumulator <= 12'h005;
    eff_addr <= 12'h030;
    exec_op(12'h002);
    apb(1'b0, OFS_STATUS, 0);
    chk("pending set", rd[ST_RETPEND], 1);
    apb(1'b0, OFS_SAVE, 0);
    chk("save reg", rd[1:0], 2'b11);
    pulse(5);
    exec_op(12'h201);
    chk("restore pc", pc_q, 13'h1030);
    chk("restore bank", bank_bit, 1);
    chk("restore pc13", pc_bit_thirteen, 1);
    apb(1'b0, OFS_STATUS, 0);
    chk("pending cleared", rd[ST_RETPEND], 0);
  endtask

  task automatic t_irq();
    exec_op(12'h004);
    chk("enable set", interrupt_enable_q, 1);
    pulse(4);
    chk("no request", interrupt_taken_flag, 0);
    @(posedge pclk);
    req <= 3'b010;
    first_indirect_fetch <= 1'b1;
    pulse(4);
    chk("indirect blocks", interrupt_taken_flag, 0);
    @(posedge pclk);
    first_indirect_fetch <= 1'b0;
    pulse(4);
    chk("taken", interrupt_taken_flag, 1);
    chk("enable dropped", interrupt_enable_q, 0);
    chk("force", fetch_addr_force, 1);
    chk("vector", fetch_addr, 13'h0002);
    pulse(4);
    chk("taken reset", interrupt_taken_flag, 0);
    chk("stays off", interrupt_enable_q, 0);
    @(posedge pclk);
    req <= 3'b000;
    exec_op(12'h004);
    exec_op(12'h008);
    chk("inhibit", interrupt_enable_q, 0);
    chk("inhibit done", done_at, 1);
    apb(1'b1, OFS_CTRL, 32'h3);
    apb(1'b0, OFS_STATUS, 0);
    chk("status enable", rd[ST_IEN], 1);
    apb(1'b1, OFS_CTRL, 32'h5);
    apb(1'b0, OFS_STATUS, 0);
    chk("software clear", rd[ST_IEN], 0);
    apb(1'b1, OFS_CTRL, 32'h3);
    pulse(6);
    chk("master clear", interrupt_enable_q, 0);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", rd, 0);
    chk("no error", pslverr, 0);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {fetch_phase_4, fetch_phase_5, exec_start, first_indirect_fetch} = '0;
    {instr_word, accumulator, eff_addr, adder_overflow_flag, master_clear_pulse} = '0;
    req = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_STATUS, 0);
    chk("status reset", rd, 0);
    t_skip();
    apb(1'b1, OFS_PC, 32'h0);
    t_jump();
    t_swap();
    t_return();
    t_irq();
    complete_run();
  end
endmodule
